// File: shared/swsl_regs.svh
// Timing constants and command codes for the single-wire bus master
// Operation
// - Select-by-identity sends 55h plus 64 identity bits
// - Skip-selection only with a single slave
// - Search: read bit, read complement, write choice
// - Master repeats search triplet over 64 bits
// - Reset pulse holds line low 480 us minimum
// - Reset high time 480 us before next sequence
// - Keep reset low time at most 960 us
// - Reset, selection, then function command, then data
// - Only master starts reset and time slots
// - Every slot starts with master falling edge
// - Write one low short, write zero low long
// - Read data valid 1 us, sampled before 15 us
// - Read slot start low at most 1 us
// - Selection commands are exactly eight bits
// - Idle bus high; long low resets slaves
`ifndef SWSL_REGS_SVH
`define SWSL_REGS_SVH

`define SWSL_CLK_MHZ 40
`define SWSL_RSTL_US 480
`define SWSL_RSTH_US 480
`define SWSL_PRES_SMP_US 70
`define SWSL_SLOT_US 70
`define SWSL_REC_US 2
`define SWSL_LOW1_US 6
`define SWSL_LOW0_US 60
`define SWSL_RDLOW_US 1
`define SWSL_RDSMP_US 13

`define SWSL_RSTL_CYC (`SWSL_RSTL_US * `SWSL_CLK_MHZ)
`define SWSL_RSTH_CYC (`SWSL_RSTH_US * `SWSL_CLK_MHZ)
`define SWSL_PRES_SMP_CYC (`SWSL_PRES_SMP_US * `SWSL_CLK_MHZ)
`define SWSL_SLOT_CYC ((`SWSL_SLOT_US + `SWSL_REC_US) * `SWSL_CLK_MHZ)
`define SWSL_LOW1_CYC (`SWSL_LOW1_US * `SWSL_CLK_MHZ)
`define SWSL_LOW0_CYC (`SWSL_LOW0_US * `SWSL_CLK_MHZ)
`define SWSL_RDLOW_CYC (`SWSL_RDLOW_US * `SWSL_CLK_MHZ)
`define SWSL_RDSMP_CYC (`SWSL_RDSMP_US * `SWSL_CLK_MHZ)

`define SWSL_CMD_MATCH 8'h55
`define SWSL_CMD_SKIP 8'hcc
`define SWSL_CMD_SEARCH 8'hf0
`define SWSL_CMD_READID 8'h33

`endif

// File: shared/swsl_pkg.sv
// Types shared by the single-wire bus master modules
package swsl_pkg;
	typedef enum logic [1:0] {SK_RESET, SK_WR0, SK_WR1, SK_READ} swsl_slot_t;

	typedef enum logic [2:0] {
		OP_RESET, OP_WRITE_BYTE, OP_READ_BYTE, OP_SKIP, OP_MATCH, OP_READ_ID, OP_SEARCH
	} swsl_op_t;

	typedef enum {ST_IDLE, ST_RESET, ST_SEND, ST_RECV, ST_SEARCH} swsl_state_t;

	typedef enum logic [1:0] {NX_DONE, NX_RECV, NX_SEARCH} swsl_next_t;

	typedef struct packed {
		logic busy;
		swsl_slot_t kind;
		logic [15:0] cnt;
		logic [15:0] low_len;
		logic [15:0] smp_at;
		logic [15:0] end_at;
		logic bitv;
		logic done;
		logic oe;
	} swsl_tmr_t;

	typedef struct packed {
		swsl_state_t st;
		logic wait_slot;
		logic [71:0] tx;
		logic [6:0] nbits;
		swsl_next_t after;
		logic [1:0] step;
		logic b0;
		logic [63:0] id;
		logic [7:0] rdata;
		logic presence;
		logic err;
		logic done;
	} swsl_ctl_t;
endpackage : swsl_pkg

// File: shared/swsl_slot_if.sv
// Slot request channel between the sequencer and the slot timer
`timescale 1ns/1ps
`default_nettype none
interface swsl_slot_if;
	import swsl_pkg::*;
	logic req;
	swsl_slot_t kind;
	logic done;
	logic bit_val;
	modport ctrl(output req, output kind, input done, input bit_val);
	modport timer(input req, input kind, output done, output bit_val);
endinterface : swsl_slot_if
`default_nettype wire

// File: verilog/swsl_slot_timer.sv
// Line timing for one reset or time slot of the single-wire bus
`timescale 1ns/1ps
`default_nettype none
`include "swsl_regs.svh"
module swsl_slot_timer import swsl_pkg::*; #(
	parameter int RSTL_CYC = `SWSL_RSTL_CYC,
	parameter int RSTH_CYC = `SWSL_RSTH_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	swsl_slot_if.timer sif,
	input wire logic line_in,
	output logic line_oe
);
	swsl_tmr_t r, n;

	// ----------------------------------------
	// Slot sequencing
	// ----------------------------------------
	always_comb begin
		n = r;
		n.done = 1'b0;
		if (!r.busy) begin
			if (sif.req) begin
				n.busy = 1'b1;
				n.kind = sif.kind;
				n.cnt = 16'h0000;
				case (sif.kind)
					SK_RESET: begin
						n.low_len = 16'(RSTL_CYC);
						n.smp_at = 16'(RSTL_CYC + `SWSL_PRES_SMP_CYC);
						n.end_at = 16'(RSTL_CYC + RSTH_CYC - 1);
					end
					SK_WR0: begin
						n.low_len = 16'(`SWSL_LOW0_CYC);
						n.smp_at = 16'(`SWSL_SLOT_CYC - 1);
						n.end_at = 16'(`SWSL_SLOT_CYC - 1);
					end
					SK_WR1: begin
						n.low_len = 16'(`SWSL_LOW1_CYC);
						n.smp_at = 16'(`SWSL_SLOT_CYC - 1);
						n.end_at = 16'(`SWSL_SLOT_CYC - 1);
					end
					default: begin
						n.low_len = 16'(`SWSL_RDLOW_CYC);
						n.smp_at = 16'(`SWSL_RDSMP_CYC);
						n.end_at = 16'(`SWSL_SLOT_CYC - 1);
					end
				endcase
			end
		end else begin
			n.cnt = r.cnt + 16'h0001;
			// Reset slot reports presence as a one; read slot reports the line level
			if (r.cnt == r.smp_at) begin
				n.bitv = (r.kind == SK_RESET) ? !line_in : line_in;
			end
			if (r.cnt == r.end_at) begin
				n.busy = 1'b0;
				n.done = 1'b1;
			end
		end
		// Line driven only inside a slot's low phase, so the bus idles high
		n.oe = n.busy && (n.cnt < n.low_len);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign sif.done = r.done;
	assign sif.bit_val = r.bitv;
	assign line_oe = r.oe;
endmodule : swsl_slot_timer
`default_nettype wire

// File: verilog/swsl_master.sv
// Single-wire bus master: reset, selection, search and byte transfers
`timescale 1ns/1ps
`default_nettype none
`include "swsl_regs.svh"
module swsl_master import swsl_pkg::*; #(
	parameter int RSTL_CYC = `SWSL_RSTL_CYC,
	parameter int RSTH_CYC = `SWSL_RSTH_CYC
) (
	input wire logic I_MCLK,
	input wire logic I_RST_N,
	input wire logic I_CMD_VALID,
	input wire logic [2:0] I_CMD_OP,
	input wire logic [7:0] I_WDATA,
	input wire logic [63:0] I_ID,
	output logic O_CMD_READY,
	output logic O_DONE,
	output logic [7:0] O_RDATA,
	output logic [63:0] O_ID,
	output logic O_PRESENCE,
	output logic O_ERR,
	input wire logic I_LINE,
	output logic O_LINE_O,
	output logic O_LINE_OE
);
	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic rst_meta_r;
	logic rst_sync_r;

	always_ff @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	// ----------------------------------------
	// Slot timer
	// ----------------------------------------
	swsl_slot_if sif();

	swsl_slot_timer #(
		.RSTL_CYC(RSTL_CYC),
		.RSTH_CYC(RSTH_CYC)
	) u_timer (
		.clk(I_MCLK),
		.rst_n(rst_sync_r),
		.sif(sif),
		.line_in(I_LINE),
		.line_oe(O_LINE_OE)
	);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	swsl_ctl_t r, n;
	swsl_op_t op;

	assign op = swsl_op_t'(I_CMD_OP);

	always_comb begin
		n = r;
		n.done = 1'b0;
		sif.req = 1'b0;
		sif.kind = SK_READ;
		case (r.st)
			ST_IDLE: begin
				if (I_CMD_VALID) begin
					n.err = 1'b0;
					n.wait_slot = 1'b0;
					n.step = 2'd0;
					n.after = NX_DONE;
					n.nbits = 7'd8;
					case (op)
						OP_RESET: begin
							n.st = ST_RESET;
						end
						OP_WRITE_BYTE: begin
							n.st = ST_SEND;
							n.tx = {64'h0, I_WDATA};
						end
						OP_READ_BYTE: begin
							n.st = ST_RECV;
						end
						OP_SKIP: begin
							n.st = ST_SEND;
							n.tx = {64'h0, `SWSL_CMD_SKIP};
						end
						OP_MATCH: begin
							n.st = ST_SEND;
							n.tx = {I_ID, `SWSL_CMD_MATCH};
							n.nbits = 7'd72;
						end
						OP_READ_ID: begin
							n.st = ST_SEND;
							n.tx = {64'h0, `SWSL_CMD_READID};
							n.after = NX_RECV;
						end
						OP_SEARCH: begin
							n.st = ST_SEND;
							// Preferred branch bits ride behind the command code
							n.tx = {I_ID, `SWSL_CMD_SEARCH};
							n.after = NX_SEARCH;
						end
						default: begin
							n.done = 1'b1;
							n.err = 1'b1;
						end
					endcase
				end
			end
			ST_RESET: begin
				sif.kind = SK_RESET;
				sif.req = !r.wait_slot;
				n.wait_slot = 1'b1;
				if (sif.done) begin
					n.presence = sif.bit_val;
					n.st = ST_IDLE;
					n.done = 1'b1;
				end
			end
			ST_SEND: begin
				sif.kind = r.tx[0] ? SK_WR1 : SK_WR0;
				sif.req = !r.wait_slot;
				n.wait_slot = 1'b1;
				if (sif.done) begin
					n.wait_slot = 1'b0;
					n.tx = {1'b0, r.tx[71:1]};
					n.nbits = r.nbits - 7'd1;
					if (r.nbits == 7'd1) begin
						case (r.after)
							NX_RECV: begin
								n.st = ST_RECV;
								n.nbits = 7'd64;
							end
							NX_SEARCH: begin
								n.st = ST_SEARCH;
								n.nbits = 7'd64;
							end
							default: begin
								n.st = ST_IDLE;
								n.done = 1'b1;
							end
						endcase
					end
				end
			end
			ST_RECV: begin
				sif.kind = SK_READ;
				sif.req = !r.wait_slot;
				n.wait_slot = 1'b1;
				if (sif.done) begin
					n.wait_slot = 1'b0;
					n.id = {sif.bit_val, r.id[63:1]};
					n.nbits = r.nbits - 7'd1;
					if (r.nbits == 7'd1) begin
						n.rdata = n.id[63:56];
						n.st = ST_IDLE;
						n.done = 1'b1;
					end
				end
			end
			ST_SEARCH: begin
				// Steps 0 and 1 read bit and complement, step 2 writes the choice
				if (r.step == 2'd2) begin
					sif.kind = n.id[63] ? SK_WR1 : SK_WR0;
				end else begin
					sif.kind = SK_READ;
				end
				sif.req = !r.wait_slot;
				n.wait_slot = 1'b1;
				if (sif.done) begin
					n.wait_slot = 1'b0;
					case (r.step)
						2'd0: begin
							n.b0 = sif.bit_val;
							n.step = 2'd1;
						end
						2'd1: begin
							n.step = 2'd2;
							// Both ones means nobody is still taking part
							if (r.b0 && sif.bit_val) begin
								n.err = 1'b1;
								n.st = ST_IDLE;
								n.done = 1'b1;
							end else begin
								n.id = {(r.b0 != sif.bit_val) ? r.b0 : r.tx[0], r.id[63:1]};
							end
						end
						default: begin
							n.step = 2'd0;
							n.tx = {1'b0, r.tx[71:1]};
							n.nbits = r.nbits - 7'd1;
							if (r.nbits == 7'd1) begin
								n.st = ST_IDLE;
								n.done = 1'b1;
							end
						end
					endcase
				end
			end
			default: begin
				n.st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge I_MCLK or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			r <= '{st: ST_IDLE, after: NX_DONE, default: '0};
		end else begin
			r <= n;
		end
	end

	assign O_CMD_READY = (r.st == ST_IDLE);
	assign O_DONE = r.done;
	assign O_RDATA = r.rdata;
	assign O_ID = r.id;
	assign O_PRESENCE = r.presence;
	assign O_ERR = r.err;
	assign O_LINE_O = 1'b0; // Open drain: only ever pulls low
endmodule : swsl_master
`default_nettype wire

// File: bench/swsl_master_props.sv
// Assertions on the master's line timing
`timescale 1ns/1ps
`default_nettype none
module swsl_master_props #(
	parameter int RSTL_CYC = 19200,
	parameter int RSTH_CYC = 19200
) (
	input wire logic I_MCLK,
	input wire logic I_RST_N,
	input wire logic O_CMD_READY,
	input wire logic O_LINE_OE
);
	int len_r, hi_r, last_r;
	// ----
	// Run lengths of the pull
	// ----
	always_ff @(posedge I_MCLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			len_r <= 0;
			hi_r <= 99999;
			last_r <= 0;
		end else begin
			len_r <= O_LINE_OE ? len_r + 1 : 0;
			hi_r <= O_LINE_OE ? 0 : hi_r + 1;
			if (O_LINE_OE) last_r <= len_r + 1;
		end
	end
	default clocking @(posedge I_MCLK); endclocking
	default disable iff (!I_RST_N);
	property p_idle_free;
		O_CMD_READY |-> !O_LINE_OE;
	endproperty
	a_idle_free: assert property (p_idle_free) else $error("pull while idle");
	property p_low_kind;
		$fell(O_LINE_OE) |-> len_r inside {40, 240, 2400, RSTL_CYC};
	endproperty
	a_low_kind: assert property (p_low_kind) else $error("odd low time");
	property p_read_low;
		$fell(O_LINE_OE) && len_r < 240 |-> len_r == 40;
	endproperty
	a_read_low: assert property (p_read_low) else $error("read low time");
	property p_reset_cap;
		O_LINE_OE |-> len_r < RSTL_CYC;
	endproperty
	a_reset_cap: assert property (p_reset_cap) else $error("low too long");
	property p_recovery;
		$rose(O_LINE_OE) |-> hi_r >= 40;
	endproperty
	a_recovery: assert property (p_recovery) else $error("no recovery");
	property p_slot_len;
		$rose(O_LINE_OE) && last_r > 0 && last_r < RSTL_CYC |-> last_r + hi_r >= 2880;
	endproperty
	a_slot_len: assert property (p_slot_len) else $error("slot too short");
	property p_reset_high;
		$rose(O_LINE_OE) && last_r == RSTL_CYC |-> hi_r >= RSTH_CYC;
	endproperty
	a_reset_high: assert property (p_reset_high) else $error("reset high short");
	property p_rst_quiet;
		$rose(I_RST_N) |-> !O_LINE_OE [*3];
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("pull after reset");
endmodule : swsl_master_props
bind swsl_master swsl_master_props #(.RSTL_CYC(RSTL_CYC), .RSTH_CYC(RSTH_CYC)) u_props (
	.I_MCLK(I_MCLK), .I_RST_N(I_RST_N), .O_CMD_READY(O_CMD_READY), .O_LINE_OE(O_LINE_OE));
`default_nettype wire

// File: bench/swsl_dev_model.sv
// Behavioural slave device on the bus
`timescale 1ns/1ps
`default_nettype none
module swsl_dev_model (
	input wire logic clk,
	input wire logic line,
	input wire logic present,
	input wire logic send,
	input wire logic [7:0] tx_byte,
	output logic pull,
	output logic [7:0] rx_byte,
	output logic [7:0] cmd
);
	int t_r = 9999, lo_r = 0, pw_r = 0, nb_r = 0;
	logic ln_r = 1'b1;
	logic [7:0] sh_r = 8'hff;
	// ----
	// Slot timer
	// ----
	// Reset threshold lies between write-zero low and reset low
	always @(posedge clk) begin
		ln_r <= line;
		t_r <= (ln_r && !line) ? 0 : t_r + 1;
		lo_r <= line ? 0 : lo_r + 1;
		pw_r <= (pw_r > 0 && pw_r < 3300) ? pw_r + 1 : 0;
		if (!ln_r && line && lo_r > 3000) begin
			pw_r <= 1;
			nb_r <= 0;
			sh_r <= tx_byte;
		end
		if (t_r == 1200 && pw_r == 0) begin
			rx_byte <= {line, rx_byte[7:1]};
			nb_r <= nb_r + 1;
			if (nb_r == 7) cmd <= {line, rx_byte[7:1]};
		end
		if (send && t_r == 600) sh_r <= sh_r >> 1;
	end
	// Silent when absent and send is low, so a search reads one and one
	assign pull = (present && pw_r > 800) || (send && t_r < 600 && !sh_r[0]);
endmodule : swsl_dev_model
`default_nettype wire

// File: bench/tb_single_wire_slave_link.sv
// Self-checking bench for the bus master
`timescale 1ns/1ps
`default_nettype none
module tb_single_wire_slave_link;
	typedef struct {int k; logic [7:0] v;} swsl_note_t;
	logic clk = 0, rst_n = 0, vld = 0, pres = 1, snd = 0;
	logic [2:0] op = 0;
	logic [7:0] wd = 0, txb = 0, wv = 0;
	logic [63:0] idv = 0;
	wire logic ln, oe, lo, pull, rdy, done, prs, err;
	wire logic [7:0] rdat, rx, cmd;
	wire logic [63:0] oid;
	int mismatches = 0, n_checks = 0;
	swsl_note_t q[$], nt;
	// Wired-AND bus: pull-up wins unless someone drives low
	assign ln = !((oe && !lo) | pull);
	// Short reset keeps the run brief; still longer than a write-zero low
	swsl_master #(.RSTL_CYC(4000), .RSTH_CYC(3600)) dut_u (
		.I_MCLK(clk), .I_RST_N(rst_n), .I_CMD_VALID(vld), .I_CMD_OP(op),
		.I_WDATA(wd), .I_ID(idv), .O_CMD_READY(rdy), .O_DONE(done), .O_RDATA(rdat),
		.O_ID(oid), .O_PRESENCE(prs), .O_ERR(err), .I_LINE(ln), .O_LINE_O(lo), .O_LINE_OE(oe));
	swsl_dev_model dev_u (.clk(clk), .line(ln), .present(pres), .send(snd),
		.tx_byte(txb), .pull(pull), .rx_byte(rx), .cmd(cmd));
	initial begin
		forever #12.5 clk = ~clk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string nm);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	task automatic run_op(input logic [2:0] o, input logic [7:0] d, input int k,
		input logic [7:0] v);
		q.push_back('{k, v});
		@(negedge clk);
		vld = 1;
		op = o;
		wd = d;
		do @(posedge clk); while (rdy !== 1'b1);
		@(negedge clk);
		vld = 0;
		for (int i = 0; i < 40000 && done !== 1'b1; i++) @(negedge clk);
		// A command that never finishes is a failure, not a silent skip
		if (done !== 1'b1) begin
			mismatches++;
			complete_run();
		end
	endtask : run_op
	// ----
	// Result checker
	// ----
	always @(posedge clk) begin
		if (done === 1'b1) begin
			nt = q.pop_front();
			case (nt.k)
				0: chk({7'h0, prs}, nt.v, "presence");
				1: begin
					chk(rdat, nt.v, "rdata");
					chk(oid[63:56], nt.v, "id_top");
				end
				2: chk({7'h0, err}, nt.v, "err");
				3: chk(rx, nt.v, "rx");
				default: chk(cmd, nt.v, "cmd");
			endcase
		end
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : complete_run
	initial begin
		repeat (150000) @(posedge clk);
		mismatches++;
		complete_run();
	end
	initial begin
		void'($urandom(32'h0923));
		txb = $urandom;
		wv = $urandom;
		idv = {$urandom, $urandom};
		repeat (3) @(negedge clk);
		rst_n = 1;
		repeat (3) @(negedge clk);
		run_op(3'h0, 8'h00, 0, 8'h01);
		run_op(3'h3, 8'h00, 4, 8'hcc);
		run_op(3'h1, wv, 3, wv);
		snd = 1;
		run_op(3'h2, 8'h00, 1, txb);
		snd = 0;
		run_op(3'h7, 8'h00, 2, 8'h01);
		pres = 0;
		run_op(3'h0, 8'h00, 0, 8'h00);
		run_op(3'h6, 8'h00, 2, 8'h01);
		// Let the checker take the last result before the verdict
		repeat (2) @(negedge clk);
		chk(8'(q.size()), 8'h00, "pending");
		complete_run();
	end
endmodule : tb_single_wire_slave_link
`default_nettype wire
